/* core/lirq_params.svh */
// constants for the local interrupt wake-up and timer block
`ifndef LIRQ_PARAMS_SVH
`define LIRQ_PARAMS_SVH

// register indices on the plain register port
`define REG_TMR_INIT 4'h0
`define REG_TMR_CUR 4'h1
`define REG_TMR_DIV 4'h2
`define REG_TMR_CTRL 4'h3
`define REG_WAKE_STAT 4'h4

// field positions
`define CTRL_PERIODIC_BIT 0
`define STAT_HALTED_BIT 0
`define STAT_PENDING_BIT 1
`define STAT_ARMED_BIT 2

// reset values
`define TMR_DIV_RESET 3'h0
`define TMR_CTRL_RESET 1'b0

// full-word access: all four byte lanes
`define FULL_WORD_BE 4'hf

// message kinds as they arrive on the interrupt bus side
`define MSG_KIND_INIT 2'h1
`define MSG_KIND_WAKE 2'h2

// start address is the message vector shifted up by this many bits
`define START_ADDR_SHIFT 12

`endif

/* core/lirq_pkg.sv */
// types shared by the wake-up / timer core and its interrupt bus receiver
package lirq_pkg;

    typedef enum logic {ST_RUN, ST_HALT} wake_state_t;

    typedef struct packed {
        logic toggle;
        logic [1:0] kind;
        logic [7:0] vector;
    } link_state_t;

    typedef struct packed {
        logic [2:0] init_pin_sync;
        logic init_pin_seen;
        logic [2:0] tog_sync;
        logic tog_seen;
        wake_state_t wstate;
        logic armed;
        logic init_pend;
        logic start_pulse;
        logic init_pulse;
        logic [31:0] start_addr;
        logic [31:0] tmr_init;
        logic [31:0] tmr_cur;
        logic [2:0] div_sel;
        logic periodic;
        logic tmr_load_pend;
        logic [7:0] presc;
        logic expire;
        logic [31:0] rdata;
        logic rd_valid;
        logic acc_err;
    } core_state_t;

endpackage

/* core/lirq_link_rx.sv */
// interrupt bus side: captures init and wake-up messages on the bus clock
`timescale 1ns/10ps
`include "lirq_params.svh"

module lirq_link_rx import lirq_pkg::*; (
    // interrupt bus clock domain
    input wire logic bus_clk,
    input wire logic bus_rst,
    // decoded message from the bus
    input wire logic msg_valid,
    input wire logic [1:0] msg_kind,
    input wire logic [7:0] msg_vector,
    // held message and event toggle towards the core domain
    output logic msg_toggle,
    output logic [1:0] held_kind,
    output logic [7:0] held_vector
);
    link_state_t st_reg;
    link_state_t st_next;

    // capture only the two kinds this block acts on; others leave the held copy alone
    always_comb begin
        st_next = st_reg;
        if (msg_valid && (msg_kind == `MSG_KIND_INIT || msg_kind == `MSG_KIND_WAKE)) begin
            st_next.kind = msg_kind;
            st_next.vector = msg_vector;
            st_next.toggle = ~st_reg.toggle;
        end
    end

    // state register on the bus clock
    always_ff @(posedge bus_clk) begin
        if (bus_rst) begin
            st_reg <= '0;
        end else begin
            st_reg <= st_next;
        end
    end

    // outputs straight from flip-flops; data is stable long before the toggle is seen
    assign msg_toggle = st_reg.toggle;
    assign held_kind = st_reg.kind;
    assign held_vector = st_reg.vector;
endmodule

/* core/local_irq_wakeup_timer.sv */
// local interrupt controller: secondary wake-up handshake, local timer, register port
// Functional notes
// - secondary processor halts after reset or init, stays halted until wake-up
// - init pin edge and init message have identical effect
// - init arriving while halted before wake-up is latched, acted on after wake-up
// - after one wake-up, later wake-ups ignored until reset or init re-arms
// - primary processor discards all wake-up messages without side effect
// - timer ticks all equal width except final tick, one timer clock long
// - shortened final tick also applies in one-shot mode
// - current count loads from initial count one clock after its write
// - registers support aligned full 32-bit reads and writes
`timescale 1ns/10ps
`include "lirq_params.svh"

module local_irq_wakeup_timer import lirq_pkg::*; #(
    parameter int PRESC_W = 8
) (
    // core clock and reset
    input wire logic clk,
    input wire logic rst,
    // interrupt bus clock domain
    input wire logic interrupt_bus_clock,
    input wire logic bus_rst,
    input wire logic msg_valid,
    input wire logic [1:0] msg_kind,
    input wire logic [7:0] msg_vector,
    // configuration and init pin
    input wire logic secondary_mode,
    input wire logic init_pin,
    // processor control outputs
    output logic cpu_halted,
    output logic cpu_start,
    output logic cpu_init,
    output logic [31:0] start_addr,
    output logic wake_armed,
    // register port
    input wire logic reg_wr,
    input wire logic reg_rd,
    input wire logic [3:0] reg_addr,
    input wire logic [31:0] reg_wdata,
    input wire logic [3:0] reg_be,
    output logic [31:0] reg_rdata,
    output logic reg_rvalid,
    output logic reg_err,
    // timer event
    output logic timer_expire
);
    core_state_t st;
    core_state_t st_next;
    logic msg_toggle;
    logic [1:0] held_kind;
    logic [7:0] held_vector;
    logic msg_evt;
    logic pin_evt;
    logic init_evt;
    logic wake_evt;
    logic full_word;
    logic [7:0] div_last;

    // elaboration check: prescaler must reach the largest divisor of 128
    if (PRESC_W < 8) begin : g_bad_presc
        $error("PRESC_W must be at least 8");
    end

    // bus-clock receiver
    lirq_link_rx u_link_rx (
        .bus_clk(interrupt_bus_clock),
        .bus_rst(bus_rst),
        .msg_valid(msg_valid),
        .msg_kind(msg_kind),
        .msg_vector(msg_vector),
        .msg_toggle(msg_toggle),
        .held_kind(held_kind),
        .held_vector(held_vector)
    );

    // events decoded from the synchronised stages two and three only
    always_comb begin
        msg_evt = (st.tog_sync[1] == st.tog_sync[2]) && (st.tog_sync[2] != st.tog_seen);
        pin_evt = (st.init_pin_sync[1] == st.init_pin_sync[2]) && st.init_pin_sync[2]
                  && !st.init_pin_seen;
        init_evt = pin_evt || (msg_evt && held_kind == `MSG_KIND_INIT);
        wake_evt = msg_evt && held_kind == `MSG_KIND_WAKE;
        full_word = reg_be == `FULL_WORD_BE;
        div_last = 8'((9'h1 << st.div_sel) - 9'h1);
    end

    // next-state logic for wake-up handshake, timer and registers
    always_comb begin
        st_next = st;
        st_next.init_pin_sync = {st.init_pin_sync[1:0], init_pin};
        st_next.tog_sync = {st.tog_sync[1:0], msg_toggle};
        if (st.init_pin_sync[1] == st.init_pin_sync[2]) begin
            st_next.init_pin_seen = st.init_pin_sync[2];
        end
        if (msg_evt) begin
            st_next.tog_seen = st.tog_sync[2];
        end
        st_next.start_pulse = 1'b0;
        st_next.init_pulse = 1'b0;
        st_next.expire = 1'b0;
        st_next.rd_valid = 1'b0;
        st_next.acc_err = 1'b0;

        // wake-up handshake
        if (!secondary_mode) begin
            // primary never sits halted: it leaves the reset halt and fetches at once
            st_next.wstate = ST_RUN;
            // primary: init restarts, wake-up has no effect at all
            if (init_evt) begin
                st_next.init_pulse = 1'b1;
                st_next.wstate = ST_RUN;
            end
        end else if (init_evt) begin
            if (st.wstate == ST_HALT && st.armed) begin
                st_next.init_pend = 1'b1;
            end else begin
                st_next.init_pulse = 1'b1;
                st_next.wstate = ST_HALT;
                st_next.armed = 1'b1;
            end
        end else if (wake_evt && st.armed) begin
            st_next.armed = 1'b0;
            if (st.init_pend) begin
                // pending init is performed now: halt again and re-arm
                st_next.init_pend = 1'b0;
                st_next.init_pulse = 1'b1;
                st_next.armed = 1'b1;
            end else begin
                st_next.wstate = ST_RUN;
                st_next.start_pulse = 1'b1;
                st_next.start_addr = 32'(held_vector) << `START_ADDR_SHIFT;
            end
        end

        // local timer: ticks of divisor width, final tick one clock
        if (st.tmr_load_pend) begin
            st_next.tmr_load_pend = 1'b0;
            st_next.tmr_cur = st.tmr_init;
            st_next.presc = '0;
        end else if (st.tmr_cur == 32'h1) begin
            st_next.expire = 1'b1;
            st_next.presc = '0;
            st_next.tmr_cur = st.periodic ? st.tmr_init : 32'h0;
        end else if (st.tmr_cur != 32'h0) begin
            if (st.presc == div_last) begin
                st_next.presc = '0;
                st_next.tmr_cur = st.tmr_cur - 32'h1;
            end else begin
                st_next.presc = st.presc + 8'h1;
            end
        end

        // register writes: full aligned words only, partial writes refused
        if (reg_wr && !full_word) begin
            st_next.acc_err = 1'b1;
        end else if (reg_wr) begin
            case (reg_addr)
                `REG_TMR_INIT: begin
                    st_next.tmr_init = reg_wdata;
                    st_next.tmr_load_pend = 1'b1;
                end
                `REG_TMR_DIV: st_next.div_sel = reg_wdata[2:0];
                `REG_TMR_CTRL: st_next.periodic = reg_wdata[`CTRL_PERIODIC_BIT];
                default: st_next.acc_err = reg_addr > `REG_WAKE_STAT;
            endcase
        end

        // register reads, answered one clock later
        if (reg_rd) begin
            st_next.rd_valid = 1'b1;
            st_next.rdata = 32'h0;
            // a refused write in the same cycle keeps its error pulse
            st_next.acc_err = st_next.acc_err || !full_word || reg_addr > `REG_WAKE_STAT;
            case (reg_addr)
                `REG_TMR_INIT: st_next.rdata = st.tmr_init;
                `REG_TMR_CUR: st_next.rdata = st.tmr_cur;
                `REG_TMR_DIV: st_next.rdata = {29'h0, st.div_sel};
                `REG_TMR_CTRL: st_next.rdata = {31'h0, st.periodic};
                `REG_WAKE_STAT: begin
                    st_next.rdata[`STAT_HALTED_BIT] = st.wstate == ST_HALT;
                    st_next.rdata[`STAT_PENDING_BIT] = st.init_pend;
                    st_next.rdata[`STAT_ARMED_BIT] = st.armed;
                end
                default: st_next.rdata = 32'h0;
            endcase
        end
    end

    // state register; after reset a secondary sits halted and armed
    always_ff @(posedge clk) begin
        if (rst) begin
            st <= '0;
            st.wstate <= ST_HALT;
            st.armed <= 1'b1;
            st.div_sel <= `TMR_DIV_RESET;
            st.periodic <= `TMR_CTRL_RESET;
        end else begin
            st <= st_next;
        end
    end

    // outputs
    assign cpu_halted = st.wstate == ST_HALT;
    assign cpu_start = st.start_pulse;
    assign cpu_init = st.init_pulse;
    assign start_addr = st.start_addr;
    assign wake_armed = st.armed;
    assign reg_rdata = st.rdata;
    assign reg_rvalid = st.rd_valid;
    assign reg_err = st.acc_err;
    assign timer_expire = st.expire;

    default clocking cb @(posedge clk); endclocking
    default disable iff (rst);

    a_primary_wake_ignored: assert property (
        (!secondary_mode && wake_evt && !init_evt) |=> !st.start_pulse && !st.init_pulse
        && st.armed == $past(st.armed)) else $error("primary reacted to wake-up");

    a_init_halts_running: assert property (
        (secondary_mode && init_evt && st.wstate == ST_RUN) |=> st.wstate == ST_HALT
        && st.armed && st.init_pulse) else $error("init did not halt and re-arm");

    a_init_latched_pending: assert property (
        (secondary_mode && init_evt && st.wstate == ST_HALT && st.armed) |=> st.init_pend
        && st.wstate == ST_HALT && !st.init_pulse) else $error("halted init not latched");

    a_wake_once_only: assert property (
        (secondary_mode && wake_evt && !init_evt && !st.armed) |=> !st.start_pulse
        && $stable(st.wstate)) else $error("unarmed wake-up accepted");

    a_wake_start_addr: assert property (
        (secondary_mode && wake_evt && !init_evt && st.armed && !st.init_pend)
        |=> st.start_pulse && st.wstate == ST_RUN && !st.armed
        && st.start_addr == {12'h0, $past(held_vector), 12'h0}) else $error("bad wake-up start");

    a_cur_load_delay: assert property (
        (reg_wr && full_word && reg_addr == `REG_TMR_INIT) |=> st.tmr_load_pend
        && st.tmr_init == $past(reg_wdata) ##1 st.tmr_cur == $past(reg_wdata, 2))
        else $error("current count not loaded one clock after write");

    a_final_tick_short: assert property (
        (st.tmr_cur == 32'h1 && !st.tmr_load_pend) |=> st.expire
        && st.tmr_cur == ($past(st.periodic) ? $past(st.tmr_init) : 32'h0))
        else $error("final tick not one clock");

    a_tick_width_held: assert property (
        (st.tmr_cur > 32'h1 && st.presc != div_last && !st.tmr_load_pend)
        |=> st.tmr_cur == $past(st.tmr_cur)) else $error("count moved mid tick");

    a_partial_refused: assert property (
        (reg_wr && !full_word) |=> st.acc_err && $stable(st.tmr_init) && $stable(st.div_sel))
        else $error("partial write not refused");
endmodule

/* verification/lirq_bus_peer.sv */
// far-side sender of init and wake-up messages on the interrupt bus
`timescale 1ns/10ps
`include "lirq_params.svh"

module lirq_bus_peer import lirq_pkg::*; #(
    parameter int INIT_GAP = 40,
    parameter int WAKE_GAP = 20
) (
    // interrupt bus side
    input wire logic bus_clk,
    output logic msg_valid,
    output logic [1:0] msg_kind,
    output logic [7:0] msg_vector
);
    initial begin
        msg_valid = 1'b0;
        msg_kind = 2'h0;
        msg_vector = 8'h00;
    end

    // one message; idle lines then show the inverse so stale values never pass
    task automatic send(input logic [1:0] kind, input logic [7:0] vec);
        @(posedge bus_clk);
        msg_valid <= 1'b1;
        msg_kind <= kind;
        msg_vector <= vec;
        @(posedge bus_clk);
        msg_valid <= 1'b0;
        msg_kind <= ~kind;
        msg_vector <= ~vec;
        repeat (10) @(posedge bus_clk);
    endtask

    // boot sequence: init, long pause, two wake-ups each followed by a pause
    task automatic boot(input logic [7:0] vec);
        send(`MSG_KIND_INIT, vec);
        repeat (INIT_GAP) @(posedge bus_clk);
        send(`MSG_KIND_WAKE, vec);
        repeat (WAKE_GAP) @(posedge bus_clk);
        send(`MSG_KIND_WAKE, vec);
        repeat (WAKE_GAP) @(posedge bus_clk);
    endtask
endmodule

/* verification/tb.sv */
// self-checking testbench for the wake-up handshake and local timer
`timescale 1ns/10ps
`include "lirq_params.svh"
`define CHK(n, e, g) chk(n, 32'(e), 32'(g))

module tb import lirq_pkg::*; ;
    logic clk = 0, rst = 1, bclk = 0, brst = 1, sec = 1, pin = 0, reg_wr = 0, reg_rd = 0;
    logic [3:0] reg_addr = 4'h0, reg_be = 4'hf;
    logic [31:0] reg_wdata = 32'h0, seed = 32'hcf9b;
    logic msg_valid, cpu_halted, cpu_start, cpu_init, wake_armed, reg_rvalid, reg_err, texp;
    logic [1:0] msg_kind;
    logic [7:0] msg_vector;
    logic [31:0] start_addr, reg_rdata;
    int miscompares = 0, cmp_count = 0, n_start = 0, n_init = 0, n_exp = 0;

    always #4 clk = ~clk;
    initial begin
        #1.7;
        forever #6 bclk = ~bclk;
    end

    lirq_bus_peer u_peer (.bus_clk(bclk), .msg_valid(msg_valid), .msg_kind(msg_kind),
        .msg_vector(msg_vector));

    local_irq_wakeup_timer u_dut (.clk(clk), .rst(rst), .interrupt_bus_clock(bclk),
        .bus_rst(brst), .msg_valid(msg_valid), .msg_kind(msg_kind), .msg_vector(msg_vector),
        .secondary_mode(sec), .init_pin(pin), .cpu_halted(cpu_halted), .cpu_start(cpu_start),
        .cpu_init(cpu_init), .start_addr(start_addr), .wake_armed(wake_armed),
        .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
        .reg_be(reg_be), .reg_rdata(reg_rdata), .reg_rvalid(reg_rvalid), .reg_err(reg_err),
        .timer_expire(texp));

    // count event pulses
    always @(posedge clk) begin
        if (cpu_start === 1'b1) n_start++;
        if (cpu_init === 1'b1) n_init++;
        if (texp === 1'b1) n_exp++;
    end

    function automatic logic [31:0] xs();
        logic [31:0] s;
        s = seed;
        s ^= s << 13;
        s ^= s >> 17;
        s ^= s << 5;
        seed = s;
        return s;
    endfunction

    task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
        cmp_count++;
        if (g !== e) begin
            miscompares++;
            $display("wrong value %s expected %h seen %h", n, e, g);
        end
    endtask

    task automatic wrap_up();
        $display("compares %0d mismatches %0d", cmp_count, miscompares);
        if (miscompares == 0 && cmp_count > 0)
            $display("TB: PASS");
        else
            $display("TB: FAIL");
        $finish;
    endtask

    task automatic do_reset(input logic mode);
        @(posedge clk);
        rst <= 1'b1;
        brst <= 1'b1;
        sec <= mode;
        repeat (8) @(posedge clk);
        rst <= 1'b0;
        brst <= 1'b0;
        repeat (6) @(posedge clk);
    endtask

    // one register access; the answer stands in the cycle after the taken edge
    task automatic acc(input logic w, input logic [3:0] a, input logic [31:0] d,
        input logic [3:0] be, output logic [31:0] q, output logic e);
        @(posedge clk);
        reg_wr <= w;
        reg_rd <= !w;
        reg_addr <= a;
        reg_wdata <= d;
        reg_be <= be;
        @(posedge clk);
        reg_wr <= 1'b0;
        reg_rd <= 1'b0;
        #1;
        q = reg_rdata;
        e = reg_err;
        `CHK("rvalid", !w, reg_rvalid);
    endtask

    // one-shot countdown watched by a read every cycle
    task automatic tmr(input logic [31:0] n, input logic [2:0] ds);
        logic [31:0] q, prev;
        logic e;
        int last, t, ne;
        acc(1'b1, `REG_TMR_DIV, {29'h0, ds}, 4'hf, q, e);
        acc(1'b0, `REG_TMR_DIV, 32'h0, 4'hf, q, e);
        `CHK("div", {29'h0, ds}, q);
        acc(1'b1, `REG_TMR_CTRL, 32'h0, 4'hf, q, e);
        acc(1'b1, `REG_TMR_INIT, n, 4'hf, q, e);
        ne = n_exp;
        prev = n;
        last = -1;
        @(posedge clk);
        reg_rd <= 1'b1;
        reg_addr <= `REG_TMR_CUR;
        for (t = 0; t < 400 && prev !== 32'h0; t++) begin
            @(posedge clk);
            #1;
            if (t == 0)
                `CHK("cur_load", n, reg_rdata);
            else if (reg_rdata !== prev) begin
                `CHK("step", prev - 1, reg_rdata);
                if (reg_rdata === 32'h0)
                    `CHK("final", 1, t - last);
                else if (last >= 0)
                    `CHK("width", 1 << ds, t - last);
                last = t;
                prev = reg_rdata;
            end
        end
        reg_rd <= 1'b0;
        if (prev !== 32'h0) begin
            miscompares++;
            wrap_up();
        end
        repeat (4) @(posedge clk);
        `CHK("expire", ne + 1, n_exp);
    endtask

    initial begin
        logic [31:0] q, n, v;
        logic e;
        do_reset(1'b1);
        `CHK("halted", 1'b1, cpu_halted);
        `CHK("armed", 1'b1, wake_armed);
        tmr(32'h3, 3'h7);
        n = 32'(3 + xs() % 4);
        tmr(n, 3'(xs() % 4));
        acc(1'b1, `REG_TMR_INIT, xs(), 4'h3, q, e);
        `CHK("part_err", 1'b1, e);
        acc(1'b0, `REG_TMR_INIT, 32'h0, 4'hf, q, e);
        `CHK("part_keep", n, q);
        acc(1'b0, 4'h5, 32'h0, 4'hf, q, e);
        `CHK("unmapped", 32'h0, q);
        `CHK("unmapped_err", 1'b1, e);
        // periodic reload: divide by one, count two, so an expiry every other clock
        acc(1'b1, `REG_TMR_DIV, 32'h0, 4'hf, q, e);
        acc(1'b1, `REG_TMR_CTRL, 32'h1, 4'hf, q, e);
        acc(1'b1, `REG_TMR_INIT, 32'h2, 4'hf, q, e);
        n = n_exp;
        repeat (21) @(posedge clk);
        `CHK("periodic", n + 9, n_exp);
        acc(1'b1, `REG_TMR_CTRL, 32'h0, 4'hf, q, e);
        // init while halted is held until a wake-up arrives
        u_peer.send(`MSG_KIND_INIT, 8'(xs()));
        `CHK("init_held", 0, n_init);
        acc(1'b0, `REG_WAKE_STAT, 32'h0, 4'hf, q, e);
        `CHK("pending", 1'b1, q[`STAT_PENDING_BIT]);
        u_peer.send(`MSG_KIND_WAKE, 8'(xs()));
        `CHK("init_done", 1, n_init);
        `CHK("no_start", 0, n_start);
        `CHK("halted2", 1'b1, cpu_halted);
        `CHK("rearmed", 1'b1, wake_armed);
        // full boot sequence; the second wake-up starts the processor
        v = xs();
        u_peer.boot(v[7:0]);
        `CHK("boot_start", 1, n_start);
        `CHK("addr", {24'h0, v[7:0]} << `START_ADDR_SHIFT, start_addr);
        `CHK("running", 1'b0, cpu_halted);
        `CHK("disarmed", 1'b0, wake_armed);
        u_peer.send(`MSG_KIND_WAKE, ~v[7:0]);
        `CHK("extra_wake", 1, n_start);
        `CHK("addr_kept", {24'h0, v[7:0]} << `START_ADDR_SHIFT, start_addr);
        // init by pin while running
        @(posedge clk);
        pin <= 1'b1;
        repeat (12) @(posedge clk);
        pin <= 1'b0;
        repeat (4) @(posedge clk);
        `CHK("pin_init", 3, n_init);
        `CHK("pin_halt", 1'b1, cpu_halted);
        `CHK("pin_arm", 1'b1, wake_armed);
        u_peer.send(`MSG_KIND_WAKE, v[15:8]);
        `CHK("restart", 2, n_start);
        `CHK("addr2", {24'h0, v[15:8]} << `START_ADDR_SHIFT, start_addr);
        u_peer.send(`MSG_KIND_INIT, v[23:16]);
        `CHK("msg_init", 4, n_init);
        `CHK("msg_halt", 1'b1, cpu_halted);
        // primary processor ignores wake-ups
        do_reset(1'b0);
        `CHK("prim_run", 1'b0, cpu_halted);
        u_peer.send(`MSG_KIND_WAKE, v[31:24]);
        `CHK("prim_start", 2, n_start);
        `CHK("prim_addr", 32'h0, start_addr);
        `CHK("prim_halt", 1'b0, cpu_halted);
        wrap_up();
    end

    // cut a hang short
    initial begin
        repeat (60000) @(posedge clk);
        miscompares++;
        wrap_up();
    end
endmodule
